// ### core/cco_clock_output_ctrl.sv
/*
  Output gating, soft stop and power-down control of a clock synthesizer.
  Assumes a serial framing block on i_clk issues single byte commands,
  and that each clock output has a gate closed in the low phase of the
  complement processor clock, steered by the o_*_run levels.
*/
`timescale 1ns/1ps
module cco_clock_output_ctrl
  import cco_pkg::*;
#(
  parameter int RESTART_WAIT = RESTART_MAX_CYCLES - SYNC_MARGIN_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_proc_clk_comp,
  input wire logic i_powerdown_n,
  input wire logic i_serial_ref_stop_elig,
  input wire logic i_cfg_wr,
  input wire logic i_cfg_rd,
  input wire logic [7:0] i_cfg_cmd,
  input wire logic [7:0] i_cfg_wdata,
  output logic [7:0] o_cfg_rdata,
  output logic o_cfg_ack,
  output logic o_cfg_err,
  output logic o_serial48_high_drive,
  output logic o_alt_48m_mode,
  output logic o_fs_test_mode,
  output logic o_serial_ref_200m,
  output logic o_spread_center,
  output logic o_spread_on,
  output logic o_osc_pll_powerdown,
  output logic [5:0] o_pci_run,
  output logic [2:0] o_freerun_run,
  output logic o_serial_ref_run,
  output logic [3:0] o_mid66_run,
  output logic o_display48_run,
  output logic o_serial48_run,
  output logic [1:0] o_copy_run,
  output logic o_proc_run,
  output logic o_proc_true_hold_high,
  output logic o_proc_comp_oe_n
);

  // ----------------------------------------------------------------
  // Core domain state.
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] b3;
    logic [7:0] b4;
    logic [7:0] b5;
    logic [7:0] b6;
    logic [7:0] rdata;
    logic ack;
    logic err;
    logic pd_s1;
    logic pd_s2;
    cco_pd_state_t st;
    logic [WAKE_CNT_W-1:0] cnt;
    logic allow;
    logic pll_pd;
    cco_xcfg_t xcfg;
  } cco_core_t;

  // ----------------------------------------------------------------
  // Link domain state, clocked by the complement processor clock.
  // ----------------------------------------------------------------
  typedef struct packed {
    logic rst_s1;
    logic rst_s2;
    logic pd_s1;
    logic pd_s2;
    logic pd_s3;
    logic allow_s1;
    logic allow_s2;
    cco_xcfg_t cfg_s1;
    cco_xcfg_t cfg_s2;
    logic halt_d;
    logic [5:0] pci_run;
    logic [2:0] fr_run;
    logic sr_run;
    logic [3:0] m66_run;
    logic d48_run;
    logic s48_run;
    logic [1:0] copy_run;
    logic proc_run;
    logic proc_hold;
    logic proc_oe_n;
  } cco_link_t;

  cco_core_t r_reg; // Registered core state.
  cco_core_t r_next; // Its next value.
  cco_link_t l_reg; // Registered link state.
  cco_link_t l_next; // Its next value.
  logic [6:0] ofs; // Byte offset of the command.
  logic cmd_ok; // Command is a byte operation.
  logic halt; // Link side: clocks must be held.
  logic soft_stop; // Link side: soft stop asserted.

  // Offset sits in the low seven bits of a byte command.
  assign ofs = i_cfg_cmd[6:0];
  assign cmd_ok = (i_cfg_cmd[7:5] == CMD_BYTE_OP);

  // ----------------------------------------------------------------
  // Core next state: register file and power-down sequencer.
  // ----------------------------------------------------------------
  always_comb begin
    r_next = r_reg;
    r_next.ack = 1'b0;
    r_next.err = 1'b0;
    // Two flops catch the pin; only the second is read.
    r_next.pd_s1 = i_powerdown_n;
    r_next.pd_s2 = r_reg.pd_s1;
    // Settings are registered here so the crossing starts at a flop.
    r_next.xcfg.sr_elig = i_serial_ref_stop_elig;
    r_next.xcfg.soft_stop_bit = r_reg.b3[B3_SOFT_STOP];
    r_next.xcfg.pci_en = r_reg.b3[5:0];
    r_next.xcfg.s48_en = r_reg.b4[B4_S48_EN];
    r_next.xcfg.fr_elig = r_reg.b4[5:3];
    r_next.xcfg.fr_en = r_reg.b4[2:0];
    r_next.xcfg.d48_en = r_reg.b5[B5_DISP48_EN];
    r_next.xcfg.m66_en = {r_reg.b5[B5_MID66_3_EN], r_reg.b5[2:0]};
    r_next.xcfg.copy_en = r_reg.b6[1:0];
    // A command is answered one cycle after it is taken.
    if (i_cfg_wr || i_cfg_rd) begin
      r_next.ack = 1'b1;
      r_next.rdata = 8'h00;
      // Reserved bits keep their reset value whatever is written.
      if (!cmd_ok) begin
        r_next.err = 1'b1;
      end else if (ofs == OFS_STOP_PCI_EN) begin
        if (i_cfg_wr) begin
          r_next.b3 = (i_cfg_wdata & WMASK_B3) | (RST_B3 & ~WMASK_B3);
        end
        r_next.rdata = r_reg.b3;
      end else if (ofs == OFS_S48_FREERUN) begin
        if (i_cfg_wr) begin
          r_next.b4 = (i_cfg_wdata & WMASK_B4) | (RST_B4 & ~WMASK_B4);
        end
        r_next.rdata = r_reg.b4;
      end else if (ofs == OFS_DISP48_MID66) begin
        if (i_cfg_wr) begin
          r_next.b5 = (i_cfg_wdata & WMASK_B5) | (RST_B5 & ~WMASK_B5);
        end
        r_next.rdata = r_reg.b5;
      end else if (ofs == OFS_SPREAD_REF) begin
        if (i_cfg_wr) begin
          r_next.b6 = (i_cfg_wdata & WMASK_B6) | (RST_B6 & ~WMASK_B6);
        end
        r_next.rdata = r_reg.b6;
      end else if (ofs == OFS_REV_VENDOR) begin
        // Read only; a write is answered and dropped.
        r_next.rdata = {REVISION_ID, VENDOR_ID};
      end else begin
        r_next.err = 1'b1;
      end
    end
    // Power-down sequencer.
    case (r_reg.st)
      PD_RUN: begin
        if (!r_reg.pd_s2) begin
          r_next.st = PD_DOWN;
          r_next.allow = 1'b0;
          r_next.pll_pd = 1'b1;
        end
      end
      PD_DOWN: begin
        if (r_reg.pd_s2) begin
          r_next.st = PD_WAKE;
          r_next.pll_pd = 1'b0;
          r_next.cnt = '0;
        end
      end
      PD_WAKE: begin
        // Wait for the PLL, leaving slack for the crossings.
        if (!r_reg.pd_s2) begin
          r_next.st = PD_DOWN;
          r_next.pll_pd = 1'b1;
        end else if (r_reg.cnt >= WAKE_CNT_W'(RESTART_WAIT - 1)) begin
          r_next.st = PD_RUN;
          r_next.allow = 1'b1;
        end else begin
          r_next.cnt = r_reg.cnt + 1'b1;
        end
      end
      default: begin
        r_next.st = PD_DOWN;
      end
    endcase
    if (!i_resetn) begin
      r_next.b3 = RST_B3;
      r_next.b4 = RST_B4;
      r_next.b5 = RST_B5;
      r_next.b6 = RST_B6;
      r_next.rdata = 8'h00;
      r_next.ack = 1'b0;
      r_next.err = 1'b0;
      r_next.pd_s1 = 1'b1;
      r_next.pd_s2 = 1'b1;
      r_next.st = PD_RUN;
      r_next.cnt = '0;
      r_next.allow = 1'b1;
      r_next.pll_pd = 1'b0;
      r_next.xcfg = '0;
    end
  end

  // Core register stage.
  always_ff @(posedge i_clk) begin
    r_reg <= r_next;
  end

  // ----------------------------------------------------------------
  // Link next state: glitch-free gating of every clock output.
  // ----------------------------------------------------------------
  // Power-down needs two low samples of the synchronised pin.
  assign halt = (!l_reg.pd_s2 && !l_reg.pd_s3) || !l_reg.allow_s2;
  assign soft_stop = !l_reg.cfg_s2.soft_stop_bit;

  always_comb begin
    l_next = l_reg;
    // Synchronisers; each first stage feeds only its second.
    l_next.rst_s1 = i_resetn;
    l_next.rst_s2 = l_reg.rst_s1;
    l_next.pd_s1 = i_powerdown_n;
    l_next.pd_s2 = l_reg.pd_s1;
    l_next.pd_s3 = l_reg.pd_s2;
    l_next.allow_s1 = r_reg.allow;
    l_next.allow_s2 = l_reg.allow_s1;
    // Settings are static while used, so a bus of levels is safe.
    l_next.cfg_s1 = r_reg.xcfg;
    l_next.cfg_s2 = l_reg.cfg_s1;
    if (!l_reg.rst_s2) begin
      l_next.halt_d = 1'b1;
      l_next.pci_run = '0;
      l_next.fr_run = '0;
      l_next.sr_run = 1'b0;
      l_next.m66_run = '0;
      l_next.d48_run = 1'b0;
      l_next.s48_run = 1'b0;
      l_next.copy_run = '0;
      l_next.proc_run = 1'b0;
      l_next.proc_hold = 1'b1;
      l_next.proc_oe_n = 1'b1;
    end else begin
      // All levels but copy_run change on one edge, so those outputs stop together.
      l_next.halt_d = halt;
      l_next.pci_run = (halt || soft_stop) ? 6'h00 : l_reg.cfg_s2.pci_en;
      l_next.fr_run = halt ? 3'h0 :
        (l_reg.cfg_s2.fr_en & ~({3{soft_stop}} & l_reg.cfg_s2.fr_elig));
      l_next.sr_run = !halt && !(soft_stop && l_reg.cfg_s2.sr_elig);
      l_next.m66_run = halt ? 4'h0 : l_reg.cfg_s2.m66_en;
      l_next.d48_run = !halt && l_reg.cfg_s2.d48_en;
      l_next.s48_run = !halt && l_reg.cfg_s2.s48_en;
      // Copy outputs follow one link cycle late.
      l_next.copy_run = l_reg.halt_d ? 2'h0 : l_reg.cfg_s2.copy_en;
      l_next.proc_run = !halt;
      l_next.proc_hold = halt;
      l_next.proc_oe_n = halt;
    end
  end

  // Link register stage; the gates close in the low phase after it.
  always_ff @(posedge i_proc_clk_comp) begin
    l_reg <= l_next;
  end

  // ----------------------------------------------------------------
  // Outputs, each straight from a flop.
  // ----------------------------------------------------------------
  assign o_cfg_rdata = r_reg.rdata;
  assign o_cfg_ack = r_reg.ack;
  assign o_cfg_err = r_reg.err;
  assign o_serial48_high_drive = r_reg.b4[B4_S48_DRIVE];
  assign o_alt_48m_mode = r_reg.b5[B5_ALT48];
  assign o_fs_test_mode = r_reg.b6[B6_FS_TEST];
  assign o_serial_ref_200m = r_reg.b6[B6_REF_200M];
  assign o_spread_center = r_reg.b6[B6_SS_CENTER];
  assign o_spread_on = r_reg.b6[B6_SS_ON];
  assign o_osc_pll_powerdown = r_reg.pll_pd;
  assign o_pci_run = l_reg.pci_run;
  assign o_freerun_run = l_reg.fr_run;
  assign o_serial_ref_run = l_reg.sr_run;
  assign o_mid66_run = l_reg.m66_run;
  assign o_display48_run = l_reg.d48_run;
  assign o_serial48_run = l_reg.s48_run;
  assign o_copy_run = l_reg.copy_run;
  assign o_proc_run = l_reg.proc_run;
  assign o_proc_true_hold_high = l_reg.proc_hold;
  assign o_proc_comp_oe_n = l_reg.proc_oe_n;

  // ----------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------
  sequence s_wr(logic [6:0] o);
    i_cfg_wr && cmd_ok && (ofs == o);
  endsequence

  property p_wr_b3;
    @(posedge i_clk) disable iff (!i_resetn)
    s_wr(OFS_STOP_PCI_EN) |=> (r_reg.b3 == (($past(i_cfg_wdata) & WMASK_B3) | 8'h40));
  endproperty
  a_wr_b3: assert property (p_wr_b3) else $error("byte three write lost");

  property p_wr_b4;
    @(posedge i_clk) disable iff (!i_resetn)
    s_wr(OFS_S48_FREERUN) |=> (o_serial48_high_drive == $past(i_cfg_wdata[7]));
  endproperty
  a_wr_b4: assert property (p_wr_b4) else $error("drive strength not set");

  property p_wr_b5;
    @(posedge i_clk) disable iff (!i_resetn)
    s_wr(OFS_DISP48_MID66) |=> (o_alt_48m_mode == $past(i_cfg_wdata[5])) && r_reg.b5[6];
  endproperty
  a_wr_b5: assert property (p_wr_b5) else $error("mode bit not set");

  property p_wr_b6;
    @(posedge i_clk) disable iff (!i_resetn)
    s_wr(OFS_SPREAD_REF) |=> (r_reg.b6[7:6] == 2'h0) && (o_spread_on == $past(i_cfg_wdata[2]));
  endproperty
  a_wr_b6: assert property (p_wr_b6) else $error("spread bits wrong");

  property p_ident;
    @(posedge i_clk) disable iff (!i_resetn)
    (i_cfg_rd && cmd_ok && ofs == OFS_REV_VENDOR) |=> o_cfg_ack && !o_cfg_err
      && (o_cfg_rdata == {REVISION_ID, VENDOR_ID});
  endproperty
  a_ident: assert property (p_ident) else $error("identity byte wrong");

  property p_pd_enter;
    @(posedge i_clk) disable iff (!i_resetn)
    (!i_powerdown_n ##1 !i_powerdown_n ##1 !i_powerdown_n) |-> ##[1:2] o_osc_pll_powerdown;
  endproperty
  a_pd_enter: assert property (p_pd_enter) else $error("PLL not powered down");

  property p_wake;
    @(posedge i_clk) disable iff (!i_resetn)
    (r_reg.st == PD_WAKE) |-> (r_reg.cnt < WAKE_CNT_W'(RESTART_WAIT)) && !r_reg.allow;
  endproperty
  a_wake: assert property (p_wake) else $error("wake wait overran");

  property p_halt_hold;
    @(posedge i_proc_clk_comp) disable iff (!l_reg.rst_s2)
    halt |=> (o_pci_run == 6'h00) && (o_mid66_run == 4'h0) && o_proc_true_hold_high
      && o_proc_comp_oe_n && !o_proc_run;
  endproperty
  a_halt_hold: assert property (p_halt_hold) else $error("clocks not held");

  property p_soft_stop;
    @(posedge i_proc_clk_comp) disable iff (!l_reg.rst_s2)
    (soft_stop && !halt) |=> (o_pci_run == 6'h00)
      && (o_serial_ref_run == !$past(l_reg.cfg_s2.sr_elig));
  endproperty
  a_soft_stop: assert property (p_soft_stop) else $error("soft stop ignored");

  property p_restart;
    @(posedge i_proc_clk_comp) disable iff (!l_reg.rst_s2)
    (!soft_stop && !halt) |=> (o_pci_run == $past(l_reg.cfg_s2.pci_en)) && o_serial_ref_run;
  endproperty
  a_restart: assert property (p_restart) else $error("restart failed");

  property p_copy_lag;
    @(posedge i_proc_clk_comp) disable iff (!l_reg.rst_s2)
    (halt ##1 halt) |=> (o_copy_run == 2'h0);
  endproperty
  a_copy_lag: assert property (p_copy_lag) else $error("copy clocks still run");

endmodule

// ### core/cco_pkg.sv
/*
  Constants and types for the clock output control block.
  Assumes a 100 MHz core clock and a byte wide command port.
*/
package cco_pkg;
  // ----------------------------------------------------------------
  // Byte command decode.
  // ----------------------------------------------------------------
  localparam logic [2:0] CMD_BYTE_OP = 3'h4;
  localparam logic [6:0] OFS_STOP_PCI_EN = 7'h03;
  localparam logic [6:0] OFS_S48_FREERUN = 7'h04;
  localparam logic [6:0] OFS_DISP48_MID66 = 7'h05;
  localparam logic [6:0] OFS_SPREAD_REF = 7'h06;
  localparam logic [6:0] OFS_REV_VENDOR = 7'h07;
  // Field positions.
  localparam int B3_SOFT_STOP = 7;
  localparam int B4_S48_DRIVE = 7;
  localparam int B4_S48_EN = 6;
  localparam int B5_DISP48_EN = 7;
  localparam int B5_ALT48 = 5;
  localparam int B5_MID66_3_EN = 4;
  localparam int B6_FS_TEST = 5;
  localparam int B6_REF_200M = 4;
  localparam int B6_SS_CENTER = 3;
  localparam int B6_SS_ON = 2;
  // Reset values; reserved bits read back as these.
  localparam logic [7:0] RST_B3 = 8'hff;
  localparam logic [7:0] RST_B4 = 8'h47;
  localparam logic [7:0] RST_B5 = 8'hdf;
  localparam logic [7:0] RST_B6 = 8'h03;
  // Bits that software may change.
  localparam logic [7:0] WMASK_B3 = 8'hbf;
  localparam logic [7:0] WMASK_B4 = 8'hff;
  localparam logic [7:0] WMASK_B5 = 8'hb7;
  localparam logic [7:0] WMASK_B6 = 8'h3f;
  // Identity nibbles; the values are arbitrary.
  localparam logic [3:0] REVISION_ID = 4'h2;
  localparam logic [3:0] VENDOR_ID = 4'h5;
  // ----------------------------------------------------------------
  // Timing.
  // ----------------------------------------------------------------
  localparam real CLK_PERIOD_NS = 10.0;
  localparam real RESTART_MAX_MS = 3.0;
  // Longest time, strictly less than the limit.
  localparam int RESTART_MAX_CYCLES = int'(RESTART_MAX_MS * 1.0e6 / CLK_PERIOD_NS) - 1;
  // Slack left for the synchronisers on both sides.
  localparam int SYNC_MARGIN_CYCLES = 32;
  localparam int WAKE_CNT_W = 19;
  // ----------------------------------------------------------------
  // Types.
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {PD_RUN, PD_DOWN, PD_WAKE} cco_pd_state_t;
  // Quasi-static settings handed to the link domain.
  typedef struct packed {
    logic sr_elig;
    logic soft_stop_bit;
    logic [5:0] pci_en;
    logic s48_en;
    logic [2:0] fr_elig;
    logic [2:0] fr_en;
    logic d48_en;
    logic [3:0] m66_en;
    logic [1:0] copy_en;
  } cco_xcfg_t;
endpackage

// ### dv/cco_host_model.sv
/*
  Host model for the byte command port of the clock output control block.
  Assumes the bench waits for reset release before asking for a transfer.
*/
`timescale 1ns/1ps
module cco_host_model
  import cco_pkg::*;
(
  input wire logic i_clk,
  input wire logic [7:0] i_rdata,
  input wire logic i_ack,
  input wire logic i_err,
  output logic o_wr,
  output logic o_rd,
  output logic [7:0] o_cmd,
  output logic [7:0] o_wdata
);
  // ----------------------------------------------------------------
  // Data that a well behaved host sends.
  // ----------------------------------------------------------------
  // Reserved bits carry their reset values, so they never steer anything.
  function automatic logic [7:0] legal(input logic [7:0] cmd, input logic [7:0] wd);
    case (cmd)
      8'h83: legal = (wd & WMASK_B3) | (RST_B3 & ~WMASK_B3);
      8'h85: legal = (wd & WMASK_B5) | (RST_B5 & ~WMASK_B5);
      8'h86: legal = (wd & WMASK_B6) | (RST_B6 & ~WMASK_B6);
      default: legal = wd;
    endcase
  endfunction

  initial begin
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_cmd = 8'h00;
    o_wdata = 8'h00;
  end

  // ----------------------------------------------------------------
  // One byte transfer: a one cycle request, then a bounded wait for ack.
  // ----------------------------------------------------------------
  task automatic xfer(input bit wr, input logic [7:0] cmd, input logic [7:0] wd,
                      output logic [7:0] rd, output logic er, output bit to);
    @(posedge i_clk);
    #1;
    o_cmd = cmd;
    o_wdata = legal(cmd, wd);
    o_wr = wr;
    o_rd = !wr;
    @(posedge i_clk);
    #1;
    // Released lines show the inverse so stale values never look valid.
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_cmd = ~o_cmd;
    o_wdata = ~o_wdata;
    to = 1'b1;
    rd = 8'h00;
    er = 1'b0;
    // The answer stands for one cycle from the edge after the request, so
    // it is looked at 1 ns after each edge, never in the edge's own step.
    for (int i = 0; i < 4; i++) begin
      if (i_ack === 1'b1) begin
        rd = i_rdata;
        er = i_err;
        to = 1'b0;
        break;
      end
      @(posedge i_clk);
      #1;
    end
  endtask
endmodule

// ### dv/cco_clock_output_ctrl_bench.sv
/*
  Self-checking bench of the clock output control block with a byte model.
  Assumes the host model drives the command port and the bench the pins.
*/
`timescale 1ns/1ps
module cco_clock_output_ctrl_bench;
  import cco_pkg::*;
  logic i_clk, i_resetn, i_proc_clk_comp, i_powerdown_n, i_serial_ref_stop_elig;
  logic i_cfg_wr, i_cfg_rd, o_cfg_ack, o_cfg_err;
  logic [7:0] i_cfg_cmd, i_cfg_wdata, o_cfg_rdata;
  logic o_serial48_high_drive, o_alt_48m_mode, o_fs_test_mode, o_serial_ref_200m;
  logic o_spread_center, o_spread_on, o_osc_pll_powerdown, o_serial_ref_run;
  logic [5:0] o_pci_run;
  logic [2:0] o_freerun_run;
  logic [3:0] o_mid66_run;
  logic [1:0] o_copy_run;
  logic o_display48_run, o_serial48_run, o_proc_run, o_proc_true_hold_high, o_proc_comp_oe_n;
  int miscompares, comparisons;
  int regs [0:7]; // Model of the byte map.
  int seed;
  // Refused codes: wrong upper bits and offsets owned elsewhere.
  logic [7:0] seed_cmds [7] = '{8'h80, 8'h81, 8'h82, 8'h88, 8'h03, 8'hc4, 8'h7f};

  cco_clock_output_ctrl #(.RESTART_WAIT(20)) u_cco_clock_output_ctrl (.*);
  cco_host_model u_cco_host_model (.i_clk, .i_rdata(o_cfg_rdata), .i_ack(o_cfg_ack),
    .i_err(o_cfg_err), .o_wr(i_cfg_wr), .o_rd(i_cfg_rd), .o_cmd(i_cfg_cmd),
    .o_wdata(i_cfg_wdata));

  // ----------------------------------------------------------------
  // Clocks; the link clock is unrelated in phase to the core clock.
  // ----------------------------------------------------------------
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  initial begin
    i_proc_clk_comp = 1'b0;
    #7.3;
    forever #24 i_proc_clk_comp = ~i_proc_clk_comp;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // One access; the model gives old data on a write and zero on a refusal.
  task automatic reg_op(input bit w, input logic [7:0] cmd, input logic [7:0] wd);
    logic [7:0] rd;
    logic er;
    bit to;
    bit ok;
    ok = cmd[7:5] == 3'b100 && cmd[6:0] >= 3 && cmd[6:0] <= 7;
    u_cco_host_model.xfer(w, cmd, wd, rd, er, to);
    if (to) begin
      miscompares++;
      stop_test();
    end
    check(er, !ok);
    check(rd, ok ? regs[cmd[2:0]] : 0);
    if (w && ok && cmd[2:0] != 3'h7) begin
      regs[cmd[2:0]] = u_cco_host_model.legal(cmd, wd);
    end
  endtask

  // Waits long enough for settings to cross, then compares every clock and mode output.
  task automatic settle_check(input bit pd);
    logic [7:0] b3, b4, b5, b6;
    logic st;
    repeat (10) @(posedge i_proc_clk_comp);
    #1;
    b3 = regs[3];
    b4 = regs[4];
    b5 = regs[5];
    b6 = regs[6];
    st = !b3[7];
    check(o_pci_run, pd ? 0 : b3[5:0] & {6{!st}});
    check(o_freerun_run, pd ? 0 : b4[2:0] & ~({3{st}} & b4[5:3]));
    check(o_serial_ref_run, pd ? 0 : !(st && i_serial_ref_stop_elig));
    check({o_mid66_run, o_display48_run}, pd ? 0 : {b5[4], b5[2:0], b5[7]});
    check({o_serial48_run, o_copy_run}, pd ? 0 : {b4[6], b6[1:0]});
    check({o_proc_true_hold_high, o_proc_comp_oe_n, o_proc_run}, {pd, pd, !pd});
    check(o_osc_pll_powerdown, pd);
    check({o_serial48_high_drive, o_alt_48m_mode}, {b4[7], b5[5]});
    check({o_fs_test_mode, o_serial_ref_200m}, {b6[5], b6[4]});
    check({o_spread_center, o_spread_on}, {b6[3], b6[2]});
  endtask

  // ----------------------------------------------------------------
  // Main sequence.
  // ----------------------------------------------------------------
  initial begin
    i_resetn = 1'b0;
    i_powerdown_n = 1'b1;
    i_serial_ref_stop_elig = 1'b0;
    miscompares = 0;
    comparisons = 0;
    seed = $urandom(32'h9d854b3c);
    regs = '{0, 0, 0, RST_B3, RST_B4, RST_B5, RST_B6, {REVISION_ID, VENDOR_ID}};
    repeat (20) @(posedge i_clk);
    #1;
    i_resetn = 1'b1;
    // Reset values of every byte, then the outputs they steer.
    for (int o = 3; o <= 7; o++) reg_op(1'b0, 8'h80 | 8'(o), 8'h00);
    settle_check(1'b0);
    // Refused codes: wrong upper bits and offsets owned elsewhere.
    foreach (seed_cmds[i]) reg_op(1'b1, seed_cmds[i], 8'($urandom));
    // Random settings, soft stop included, with a read back each time.
    repeat (8) begin
      i_serial_ref_stop_elig = 1'($urandom);
      for (int o = 3; o <= 7; o++) reg_op(1'b1, 8'h80 | 8'(o), 8'($urandom));
      for (int o = 3; o <= 7; o++) reg_op(1'b0, 8'h80 | 8'(o), 8'h00);
      settle_check(1'b0);
    end
    // Soft stop with every path eligible, then the restart.
    i_serial_ref_stop_elig = 1'b1;
    reg_op(1'b1, 8'h84, 8'h3f);
    reg_op(1'b1, 8'h83, 8'h3f);
    settle_check(1'b0);
    reg_op(1'b1, 8'h83, 8'hff);
    settle_check(1'b0);
    // Power-down entry, the wake wait, then the restart.
    i_powerdown_n = 1'b0;
    settle_check(1'b1);
    #3.7;
    i_powerdown_n = 1'b1;
    repeat (15) @(posedge i_clk);
    #1;
    check({o_pci_run, o_proc_run}, 0);
    repeat (40) @(posedge i_clk);
    settle_check(1'b0);
    stop_test();
  end

  // Limit set far above the length of the run.
  initial begin
    #900_000;
    miscompares++;
    stop_test();
  end
endmodule
